// ### src/smc_pkg.sv
// Shared constants for the supply monitor control block.
package smc_pkg;
	localparam logic [15:0] ADDR_POWER_CLEAR_CONTROL = 16'hffdd;
	localparam logic [15:0] ADDR_LOW_VOLTAGE_DETECT = 16'hffde;
	localparam logic [15:0] ADDR_LEVEL_SELECT = 16'hffdf;
	localparam int LEVEL_W = 3;
	localparam int BIT_HALT = 0;
	localparam int BIT_RESET_DISABLE = 1;
	localparam int BIT_CAUSE = 2;
	localparam int BIT_DETECT_ENABLE = 7;
	localparam int BIT_RESULT = 0;
	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam logic [2:0] CLEAR_TOUCH_MASK = 3'h7;
	localparam logic [1:0] MODE_SWITCHABLE = 2'h0;
	localparam logic [1:0] MODE_ALWAYS_ON = 2'h1;
	localparam logic [1:0] MODE_ALWAYS_OFF = 2'h2;
	localparam int CLK_HZ = 20000000;
	localparam int SETTLE_TIME_US = 2000;
	localparam int SETTLE_CYCLES = SETTLE_TIME_US * (CLK_HZ / 1000000);
endpackage

// ### src/smc_sync.sv
// Two-stage synchroniser for comparator outputs.
`timescale 1ns/10ps
module smc_sync #(
	parameter int WIDTH = 2
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	typedef struct packed {
		logic [WIDTH-1:0] first;
		logic [WIDTH-1:0] second;
	} smc_sync_state_t;

	smc_sync_state_t state;
	smc_sync_state_t next_state;

	// The first stage feeds only the second one.
	always_comb begin
		next_state.first = async_in;
		next_state.second = state.first;
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign sync_out = state.second;
endmodule // smc_sync

// ### src/smc_top.sv
// Supply monitor control: clear monitor, low-voltage detector, registers.
// How it works
// - Reset clears level select to zero.
// - Three level bits pick eight thresholds.
// - Below clear threshold asserts internal reset.
// - Option picks switchable, always-on, always-off monitor.
// - Monitor reset sets sticky cause flag.
// - Write touching bits 0-2 clears cause.
// - Below detection level raises low-voltage request.
// - Reset or STOP powers detector down.
// - Enable bit starts detection, 2 ms settle.
// - Detector stays powered after disable.
// - Request flag sets on rising edge only.
// - Control layout: cause, reset-disable, halt.
// - Detect register: enable bit 7, result bit 0.
`timescale 1ns/10ps
module smc_top #(
	parameter logic [1:0] MONITOR_MODE = smc_pkg::MODE_SWITCHABLE,
	parameter int SETTLE_COUNT = smc_pkg::SETTLE_CYCLES
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic [15:0] bus_addr,
	input wire logic bus_wr,
	input wire logic [7:0] bus_wmask,
	input wire logic [7:0] bus_wdata,
	input wire logic bus_rd,
	output logic [7:0] bus_rdata,
	input wire logic clear_below,
	input wire logic detect_below,
	input wire logic stop_mode,
	input wire logic irq_flag_clear,
	input wire logic low_voltage_irq_mask,
	output logic internal_reset,
	output logic [smc_pkg::LEVEL_W-1:0] detection_threshold,
	output logic detector_power,
	output logic detector_settled,
	output logic low_voltage_irq_flag,
	output logic low_voltage_irq
);
	import smc_pkg::*;

	localparam int SCW = $clog2(SETTLE_COUNT + 1);
	localparam logic [SCW-1:0] SETTLE_LAST = SCW'(SETTLE_COUNT);

	typedef struct packed {
		logic [LEVEL_W-1:0] level;
		logic halt;
		logic reset_disable;
		logic cause;
		logic enable;
		logic power;
		logic irq_flag;
		logic prev_detect;
		logic [SCW-1:0] settle;
		logic [7:0] rdata;
	} smc_state_t;

	smc_state_t state;
	smc_state_t next_state;
	logic [1:0] cmp_sync;
	logic clear_s;
	logic detect_s;
	logic operating;
	logic reset_enabled;
	logic detecting;
	logic result;

	smc_sync #(.WIDTH(2)) u_sync (
		.clk(clk),
		.arst_n(arst_n),
		.async_in({clear_below, detect_below}),
		.sync_out(cmp_sync)
	);
	assign clear_s = cmp_sync[1];
	assign detect_s = cmp_sync[0];

	function automatic logic [7:0] merge(input logic [7:0] old_val,
		input logic [7:0] data, input logic [7:0] mask);
		merge = (old_val & ~mask) | (data & mask);
	endfunction

	function automatic logic hit(input logic [15:0] addr,
		input logic [15:0] reg_addr);
		hit = addr == reg_addr;
	endfunction

	// Only the switchable variant listens to the software bits.
	always_comb begin
		operating = (MONITOR_MODE == MODE_ALWAYS_ON) ||
			((MONITOR_MODE == MODE_SWITCHABLE) && !state.halt);
		reset_enabled = (MONITOR_MODE == MODE_ALWAYS_ON) ||
			((MONITOR_MODE == MODE_SWITCHABLE) && !state.reset_disable);
	end

	assign internal_reset = operating && reset_enabled && clear_s;
	assign detecting = state.enable && state.power;
	assign result = detecting && detect_s;

	always_comb begin
		logic [7:0] ctrl;
		logic [7:0] det;
		logic [7:0] lvl;
		ctrl = RESET_BYTE;
		det = RESET_BYTE;
		lvl = RESET_BYTE;
		next_state = state;
		ctrl[BIT_HALT] = state.halt;
		ctrl[BIT_RESET_DISABLE] = state.reset_disable;
		ctrl[BIT_CAUSE] = state.cause;
		det[BIT_DETECT_ENABLE] = state.enable;
		det[BIT_RESULT] = result;
		lvl[LEVEL_W-1:0] = state.level;
		next_state.rdata = RESET_BYTE;
		if (bus_rd) begin
			if (hit(bus_addr, ADDR_POWER_CLEAR_CONTROL)) begin
				next_state.rdata = ctrl;
			end else if (hit(bus_addr, ADDR_LOW_VOLTAGE_DETECT)) begin
				next_state.rdata = det;
			end else if (hit(bus_addr, ADDR_LEVEL_SELECT)) begin
				next_state.rdata = lvl;
			end
		end
		if (bus_wr && hit(bus_addr, ADDR_POWER_CLEAR_CONTROL)) begin
			ctrl = merge(ctrl, bus_wdata, bus_wmask);
			next_state.halt = ctrl[BIT_HALT];
			next_state.reset_disable = ctrl[BIT_RESET_DISABLE];
			if ((bus_wmask[2:0] & CLEAR_TOUCH_MASK) != 3'h0) begin
				next_state.cause = 1'b0;
			end
		end
		if (bus_wr && hit(bus_addr, ADDR_LOW_VOLTAGE_DETECT)) begin
			det = merge(det, bus_wdata, bus_wmask);
			next_state.enable = det[BIT_DETECT_ENABLE];
			if (det[BIT_DETECT_ENABLE]) begin
				next_state.power = 1'b1;
			end
		end
		if (bus_wr && hit(bus_addr, ADDR_LEVEL_SELECT)) begin
			lvl = merge(lvl, bus_wdata, bus_wmask);
			next_state.level = lvl[LEVEL_W-1:0];
		end
		// Disabling leaves the divider on so re-enabling needs no settle.
		if (stop_mode) begin
			next_state.power = 1'b0;
		end
		if (!state.power) begin
			next_state.settle = '0;
		end else if (state.settle != SETTLE_LAST) begin
			next_state.settle = state.settle + SCW'(1);
		end
		next_state.prev_detect = result;
		if (irq_flag_clear) begin
			next_state.irq_flag = 1'b0;
		end
		// Set beats a clear arriving in the same cycle.
		if (result && !state.prev_detect) begin
			next_state.irq_flag = 1'b1;
		end
		if (internal_reset) begin
			next_state.level = '0;
			next_state.halt = 1'b0;
			next_state.reset_disable = 1'b0;
			next_state.cause = 1'b1;
			next_state.enable = 1'b0;
			next_state.power = 1'b0;
			next_state.irq_flag = 1'b0;
			next_state.prev_detect = 1'b0;
			next_state.settle = '0;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign bus_rdata = state.rdata;
	assign detection_threshold = state.level;
	assign detector_power = state.power;
	assign detector_settled = state.settle == SETTLE_LAST;
	assign low_voltage_irq_flag = state.irq_flag;
	assign low_voltage_irq = state.irq_flag && !low_voltage_irq_mask;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);

	a_reset_sets_cause: assert property (internal_reset |=> state.cause)
		else $error("Cause flag not set after monitor reset.");
	a_write_clears_cause: assert property (bus_wr && !internal_reset &&
		hit(bus_addr, ADDR_POWER_CLEAR_CONTROL) && (bus_wmask[2:0] != 3'h0)
		|=> !state.cause)
		else $error("Cause flag survived a control write.");
	a_edge_sets_flag: assert property ($rose(result) && !internal_reset
		|=> state.irq_flag)
		else $error("Request flag missed a rising edge.");
	a_level_no_reset: assert property (state.irq_flag == 1'b0 && result &&
		$past(result) && !internal_reset |=> !state.irq_flag)
		else $error("Request flag set while level stayed low.");
	a_stop_powers_off: assert property (stop_mode |=> !detector_power)
		else $error("Detector powered during stop.");
	a_stays_powered: assert property (detector_power && !stop_mode &&
		!internal_reset |=> detector_power)
		else $error("Detector powered off without stop or reset.");
	a_irq_gating: assert property (low_voltage_irq ==
		(low_voltage_irq_flag && !low_voltage_irq_mask))
		else $error("Interrupt output not gated by flag and mask.");
	a_clear_reset: assert property (operating && reset_enabled &&
		$past(clear_below, 2) && $past(clear_below, 3) |-> internal_reset)
		else $error("Internal reset missing below clear threshold.");
	a_level_zeroed: assert property (internal_reset |=> state.level == '0)
		else $error("Level select not cleared by reset.");
	a_read_level: assert property (bus_rd &&
		hit(bus_addr, ADDR_LEVEL_SELECT) |=> bus_rdata[7:LEVEL_W] == '0 &&
		bus_rdata[LEVEL_W-1:0] == $past(state.level))
		else $error("Level select readback wrong.");

	c_monitor_reset: cover property (internal_reset ##1 !internal_reset);
	c_irq_raised: cover property ($rose(low_voltage_irq));
	c_reenable: cover property (state.enable ##1 !state.enable ##1
		state.enable);
	c_settled: cover property ($rose(detector_settled));
endmodule // smc_top

// ### sim/smc_tb.sv
// Self-checking testbench for the supply monitor control block.
`timescale 1ns/10ps
module testbench;
	import smc_pkg::*;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic [15:0] bus_addr = 16'h0000;
	logic bus_wr = 1'b0;
	logic [7:0] bus_wmask = 8'h00;
	logic [7:0] bus_wdata = 8'h00;
	logic bus_rd = 1'b0;
	logic [7:0] bus_rdata;
	logic clear_below = 1'b0;
	logic detect_below = 1'b0;
	logic stop_mode = 1'b0;
	logic irq_flag_clear = 1'b0;
	logic low_voltage_irq_mask = 1'b0;
	logic internal_reset;
	logic [LEVEL_W-1:0] detection_threshold;
	logic detector_power;
	logic detector_settled;
	logic low_voltage_irq_flag;
	logic low_voltage_irq;
	int miscompares = 0;
	int total_checks = 0;
	logic [7:0] rv;
	// A short settle count keeps the run brief; the logic is the same.
	smc_top #(.MONITOR_MODE(MODE_SWITCHABLE), .SETTLE_COUNT(8)) i_smc_top (
		.clk(clk), .arst_n(arst_n), .bus_addr(bus_addr), .bus_wr(bus_wr),
		.bus_wmask(bus_wmask), .bus_wdata(bus_wdata), .bus_rd(bus_rd),
		.bus_rdata(bus_rdata), .clear_below(clear_below),
		.detect_below(detect_below), .stop_mode(stop_mode),
		.irq_flag_clear(irq_flag_clear),
		.low_voltage_irq_mask(low_voltage_irq_mask),
		.internal_reset(internal_reset),
		.detection_threshold(detection_threshold),
		.detector_power(detector_power),
		.detector_settled(detector_settled),
		.low_voltage_irq_flag(low_voltage_irq_flag),
		.low_voltage_irq(low_voltage_irq));
	logic reset_on;
	logic reset_off;
	// The fixed variants watch the same comparator and bus as the main one.
	smc_top #(.MONITOR_MODE(MODE_ALWAYS_ON), .SETTLE_COUNT(8)) i_smc_top_on (
		.clk(clk), .arst_n(arst_n), .bus_addr(bus_addr), .bus_wr(bus_wr),
		.bus_wmask(bus_wmask), .bus_wdata(bus_wdata), .bus_rd(bus_rd),
		.bus_rdata(), .clear_below(clear_below),
		.detect_below(detect_below), .stop_mode(stop_mode),
		.irq_flag_clear(irq_flag_clear),
		.low_voltage_irq_mask(low_voltage_irq_mask),
		.internal_reset(reset_on), .detection_threshold(),
		.detector_power(), .detector_settled(),
		.low_voltage_irq_flag(), .low_voltage_irq());
	smc_top #(.MONITOR_MODE(MODE_ALWAYS_OFF), .SETTLE_COUNT(8)) i_smc_top_off (
		.clk(clk), .arst_n(arst_n), .bus_addr(bus_addr), .bus_wr(bus_wr),
		.bus_wmask(bus_wmask), .bus_wdata(bus_wdata), .bus_rd(bus_rd),
		.bus_rdata(), .clear_below(clear_below),
		.detect_below(detect_below), .stop_mode(stop_mode),
		.irq_flag_clear(irq_flag_clear),
		.low_voltage_irq_mask(low_voltage_irq_mask),
		.internal_reset(reset_off), .detection_threshold(),
		.detector_power(), .detector_settled(),
		.low_voltage_irq_flag(), .low_voltage_irq());
	always #25 clk = ~clk;
	task complete_run();
		if (miscompares == 0 && total_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task chk(input string n, input logic [7:0] e, input logic [7:0] g);
		total_checks++;
		if (g !== e) begin
			$display("Error %s expected %h seen %h", n, e, g);
			miscompares++;
		end
	endtask
	task cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task wr(input logic [15:0] a, input logic [7:0] m, input logic [7:0] d);
		@(posedge clk);
		bus_wr <= 1'b1;
		bus_addr <= a;
		bus_wmask <= m;
		bus_wdata <= d;
		@(posedge clk);
		bus_wr <= 1'b0;
	endtask
	task rd(input logic [15:0] a);
		@(posedge clk);
		bus_rd <= 1'b1;
		bus_addr <= a;
		@(posedge clk);
		bus_rd <= 1'b0;
		#1 rv = bus_rdata;
	endtask
	task test_levels();
		for (int i = 0; i < 8; i++) begin
			wr(ADDR_LEVEL_SELECT, 8'hff, 8'hf8 | 8'(i));
			rd(ADDR_LEVEL_SELECT);
			chk("level", 8'(i), rv);
			chk("threshold", 8'(i), 8'(detection_threshold));
		end
		rd(16'hffe0);
		chk("unmapped", 8'h00, rv);
	endtask
	task test_clear_monitor();
		clear_below <= 1'b1;
		cyc(4);
		chk("int_reset", 8'h01, 8'(internal_reset));
		clear_below <= 1'b0;
		cyc(4);
		rd(ADDR_POWER_CLEAR_CONTROL);
		chk("ctrl_cause", 8'h04, rv);
		// A single-lane write on bit 1 still clears the cause flag.
		wr(ADDR_POWER_CLEAR_CONTROL, 8'h02, 8'h02);
		rd(ADDR_POWER_CLEAR_CONTROL);
		chk("ctrl_clr", 8'h02, rv);
		clear_below <= 1'b1;
		cyc(4);
		chk("int_reset_dis", 8'h00, 8'(internal_reset));
		chk("reset_on", 8'h01, 8'(reset_on));
		chk("reset_off", 8'h00, 8'(reset_off));
		clear_below <= 1'b0;
		wr(ADDR_POWER_CLEAR_CONTROL, 8'hff, 8'h03);
		rd(ADDR_POWER_CLEAR_CONTROL);
		chk("ctrl_halt", 8'h03, rv);
		wr(ADDR_POWER_CLEAR_CONTROL, 8'h01, 8'h00);
		cyc(4);
		wr(ADDR_POWER_CLEAR_CONTROL, 8'h02, 8'h00);
		rd(ADDR_POWER_CLEAR_CONTROL);
		chk("ctrl_start", 8'h00, rv);
	endtask
	task test_detector();
		int n;
		wr(ADDR_LOW_VOLTAGE_DETECT, 8'hff, 8'h81);
		cyc(1);
		chk("power_on", 8'h01, 8'(detector_power));
		for (n = 0; n < 20 && detector_settled !== 1'b1; n++) cyc(1);
		if (n == 20) begin
			miscompares++;
			complete_run();
		end
		detect_below <= 1'b1;
		cyc(5);
		chk("flag", 8'h01, 8'(low_voltage_irq_flag));
		chk("irq", 8'h01, 8'(low_voltage_irq));
		low_voltage_irq_mask <= 1'b1;
		cyc(1);
		chk("irq_masked", 8'h00, 8'(low_voltage_irq));
		rd(ADDR_LOW_VOLTAGE_DETECT);
		chk("detect_reg", 8'h81, rv);
		irq_flag_clear <= 1'b1;
		cyc(1);
		irq_flag_clear <= 1'b0;
		cyc(4);
		chk("flag_held_low", 8'h00, 8'(low_voltage_irq_flag));
		detect_below <= 1'b0;
		cyc(4);
		detect_below <= 1'b1;
		cyc(5);
		chk("flag_again", 8'h01, 8'(low_voltage_irq_flag));
		irq_flag_clear <= 1'b1;
		wr(ADDR_LOW_VOLTAGE_DETECT, 8'h80, 8'h00);
		irq_flag_clear <= 1'b0;
		rd(ADDR_LOW_VOLTAGE_DETECT);
		chk("result_off", 8'h00, rv);
		chk("power_kept", 8'h01, 8'(detector_power));
		wr(ADDR_LOW_VOLTAGE_DETECT, 8'h80, 8'h80);
		cyc(5);
		chk("flag_resume", 8'h01, 8'(low_voltage_irq_flag));
		low_voltage_irq_mask <= 1'b1;
		stop_mode <= 1'b1;
		cyc(2);
		chk("power_stop", 8'h00, 8'(detector_power));
		stop_mode <= 1'b0;
		wr(ADDR_LOW_VOLTAGE_DETECT, 8'h80, 8'h00);
		wr(ADDR_LOW_VOLTAGE_DETECT, 8'h80, 8'h80);
		cyc(10);
		chk("settled_wake", 8'h01, 8'(detector_settled));
		irq_flag_clear <= 1'b1;
		wr(ADDR_LOW_VOLTAGE_DETECT, 8'h80, 8'h00);
		irq_flag_clear <= 1'b0;
		wr(ADDR_LOW_VOLTAGE_DETECT, 8'h80, 8'h80);
		cyc(4);
		low_voltage_irq_mask <= 1'b0;
		cyc(1);
		chk("irq_wake", 8'h01, 8'(low_voltage_irq));
	endtask
	task test_reset();
		wr(ADDR_LEVEL_SELECT, 8'hff, 8'h06);
		wr(ADDR_LOW_VOLTAGE_DETECT, 8'hff, 8'h80);
		cyc(2);
		arst_n <= 1'b0;
		cyc(2);
		chk("threshold_rst", 8'h00, 8'(detection_threshold));
		chk("power_rst", 8'h00, 8'(detector_power));
		arst_n <= 1'b1;
		rd(ADDR_LEVEL_SELECT);
		chk("level_rst", 8'h00, rv);
		rd(ADDR_POWER_CLEAR_CONTROL);
		chk("ctrl_rst", 8'h00, rv);
	endtask
	initial begin
		repeat (10) @(posedge clk);
		arst_n <= 1'b1;
		rd(ADDR_LOW_VOLTAGE_DETECT);
		chk("detect_rst", 8'h00, rv);
		test_levels();
		test_clear_monitor();
		test_detector();
		test_reset();
		complete_run();
	end
endmodule // testbench
